/* File: sel_pkg.sv */
// Constants, register map and types for the serial echo line editor
package sel_pkg;
  localparam int unsigned LINE_DEPTH = 256;
  localparam int unsigned PTR_W      = 9;
  localparam logic [7:0]  CH_PROMPT  = 8'h3e;
  localparam logic [7:0]  CH_CARET   = 8'h5e;
  localparam logic [7:0]  CH_BSLASH  = 8'h5c;
  localparam logic [7:0]  CH_BS      = 8'h08;
  localparam logic [7:0]  CH_LF      = 8'h0a;
  localparam logic [7:0]  CH_CR      = 8'h0d;
  localparam logic [7:0]  CH_CTRL_R  = 8'h12;
  localparam logic [7:0]  CH_CTRL_U  = 8'h15;
  localparam logic [7:0]  CH_XON     = 8'h11;
  localparam logic [7:0]  CH_XOFF    = 8'h13;
  localparam logic [7:0]  CH_DEL     = 8'h7f;
  localparam logic [7:0]  CH_SPACE   = 8'h20;
  localparam logic [7:0]  CH_QMARK   = 8'h3f;
  localparam logic [7:0]  CH_CTL_OFS = 8'h40;
  localparam logic [7:0]  CH_SEMI    = 8'h3b;
  localparam logic [7:0]  CH_COMMA   = 8'h2c;
  localparam logic [7:0]  CH_QUOTE   = 8'h22;
  localparam logic [7:0]  CH_ZERO    = 8'h30;
  localparam logic [7:0]  CH_O       = 8'h4f;
  localparam logic [7:0]  CH_K       = 8'h4b;
  localparam logic [9:0]  EV_OVERFLOW = 10'd163;
  localparam logic [9:0]  EV_BINARY   = 10'd164;
  localparam logic [9:0]  EV_POWER_OK = 10'd401;
  localparam logic [9:0]  EV_SELFTEST = 10'd394;
  // Register byte addresses
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_RESP   = 8'h08;
  localparam logic [7:0] A_EVENT  = 8'h0c;
  localparam logic [7:0] A_LINE   = 8'h10;
  localparam logic [7:0] A_DESC   = 8'h14;
  // CTRL bits
  localparam int unsigned B_ECHO    = 0;
  localparam int unsigned B_VERBOSE = 1;
  localparam int unsigned B_LONG    = 2;
  localparam int unsigned B_SOFTFLW = 3;
  localparam int unsigned B_PFAIL   = 4;
  localparam int unsigned B_PUDONE  = 5;
  localparam int unsigned B_DONE    = 6;
  localparam int unsigned B_BINARY  = 7;
  localparam int unsigned B_HSON    = 8;
  localparam int unsigned B_HSOFF   = 9;
  // RESP fields
  localparam int unsigned R_KIND_LO = 10;
  localparam int unsigned R_LAST    = 12;
  localparam int unsigned R_ERRS    = 13;
  localparam logic [1:0]  K_OK      = 2'd0;
  localparam logic [1:0]  K_QUERY   = 2'd1;
  localparam logic [1:0]  K_EVENT   = 2'd2;
  typedef enum logic [4:0] {
    S_PUP, S_PROMPT, S_IDLE, S_ECHO, S_CARET, S_ERASE1, S_ERASE2,
    S_ERASE3, S_RETYPE, S_HOLD, S_RSEP, S_RBODY, S_EVT, S_DIG,
    S_COMMA, S_QUOTE1, S_DESC, S_QUOTE2, S_EOM
  } sel_state_e;
endpackage

/* File: sel_line_editor.sv */
// Serial echo line editor and verbose response generator
`timescale 1ns/1ns
// Notes on behaviour
// R01: echo mode sends '>' prompt per line
// R02: echo mode buffers line until CR or LF
// R03: control codes echo as caret plus code+64, DEL as caret plus '?'
// R04: escaped edit controls echo in caret form
// R05: unescaped XON/XOFF echoed only without soft flow
// R06: 256-char overflow reports 163, drops line
// R07: control-R retypes the buffered line
// R08: control-U clears line, prompts again
// R09: backspace or DEL erases last character
// R10: backslash escapes next character literally
// R11: verbose: one response per command, OK
// R12: verbose: query returns its data
// R13: responses joined by semicolons, end marker
// R14: failure answers EVENT code, optional text
// R15: several errors give one EVENT, rest queued
// R16: non-verbose answers only valid queries
// R17: verbose power-up sends EVENT 401 or 394
// R18: non-verbose power-up queues the event
// R19: verbose mode switchable by panel or command
// R20: echo mode echoes received characters except unescaped edit codes and soft-flow XON/XOFF
// R21: echo mode drops binary block, queues 164
// R22: after hand-off, empty buffer, new prompt
module sel_line_editor
  import sel_pkg::*;
(
  input  wire logic        pclk,        // System clock
  input  wire logic        presetn,     // Async reset, low active
  input  wire logic        psel,        // APB select
  input  wire logic        penable,     // APB enable
  input  wire logic        pwrite,      // APB direction
  input  wire logic [7:0]  paddr,       // APB byte address
  input  wire logic [31:0] pwdata,      // APB write data
  output logic             pready,      // APB ready
  output logic [31:0]      prdata,      // APB read data
  output logic             pslverr,     // APB error
  input  wire logic        panel_verbose_set, // Front panel verbose on
  input  wire logic        panel_verbose_clr, // Front panel verbose off
  input  wire logic        rx_valid,    // Received char strobe
  input  wire logic [7:0]  rx_data,     // Received char
  output logic             rx_ready,    // Editor can take char
  output logic             tx_valid,    // Char to send
  output logic [7:0]       tx_data,     // Char data
  input  wire logic        tx_ready,    // Transmitter takes char
  output logic             tx_eom,      // End marker with this char
  output logic             line_valid,  // Terminated line ready
  output logic [8:0]       line_len,    // Line length
  output logic             event_valid, // Queue event pulse
  output logic [9:0]       event_code   // Queued event code
);
  logic [7:0]  line_mem [LINE_DEPTH];
  logic [PTR_W-1:0] len_q, idx_q;
  logic        echo_q, verb_q, long_q, soft_q, pfail_q;
  logic        esc_q, ovf_q, first_q;
  sel_state_e  st_q;
  logic [7:0]  ch_q, caret_q;
  logic [1:0]  kind_q;
  logic        last_q;
  logic [9:0]  code_q, ev_q;
  logic [7:0]  qlen_q, dlen_q;
  logic [7:0]  resp_mem [LINE_DEPTH];
  logic [7:0]  desc_mem [64];
  logic [1:0]  dig_q;
  logic        ev_v_q;
  logic        resp_pend_q, pup_pend_q;

  function automatic logic is_ctl(input logic [7:0] c);
    return (c < CH_SPACE) || (c == CH_DEL);
  endfunction

  function automatic logic [7:0] dec_digit(input logic [9:0] v,
                                           input logic [1:0] i);
    logic [9:0] d;
    d = (i == 2'd0) ? v / 10'd100 :
        (i == 2'd1) ? (v / 10'd10) % 10'd10 : v % 10'd10;
    return CH_ZERO + d[7:0];
  endfunction

  wire apb_acc = psel && penable;
  wire apb_wr  = apb_acc && pwrite;
  assign pready  = 1'b1;
  assign pslverr = apb_acc && (paddr > A_DESC);
  wire tx_go = tx_valid && tx_ready;
  assign rx_ready = (st_q == S_IDLE) || (!echo_q && st_q != S_PUP);
  wire rx_go = rx_valid && rx_ready;

  // Mode bits; a CTRL write over APB or the panel moves verbose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      echo_q <= 1'b0;
      verb_q <= 1'b0;
      long_q <= 1'b0;
      soft_q <= 1'b0;
      pfail_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == A_CTRL) begin
        echo_q  <= pwdata[B_ECHO];
        long_q  <= pwdata[B_LONG];
        soft_q  <= pwdata[B_SOFTFLW];
        pfail_q <= pwdata[B_PFAIL];
        verb_q  <= pwdata[B_VERBOSE];
        if (pwdata[B_HSON]) verb_q <= 1'b1; // R19
        if (pwdata[B_HSOFF]) verb_q <= 1'b0; // R19
      end
      if (panel_verbose_set) verb_q <= 1'b1; // R19
      if (panel_verbose_clr) verb_q <= 1'b0; // R19
    end
  end

  // Response staging, written by the parser side
  always_ff @(posedge pclk) begin
    if (apb_wr && paddr == A_LINE && pwdata[15:8] != 8'h00)
      resp_mem[pwdata[15:8]] <= pwdata[7:0];
    if (apb_wr && paddr == A_DESC)
      desc_mem[pwdata[13:8]] <= pwdata[7:0];
  end

  // Line buffer storage; index reused for retype and response walk
  always_ff @(posedge pclk) begin
    if (st_q == S_IDLE && rx_go && echo_q && len_q < PTR_W'(LINE_DEPTH))
      line_mem[len_q[7:0]] <= rx_data; // R02
  end

  wire rx_nl   = rx_data == CH_CR || rx_data == CH_LF;
  wire rx_edit = rx_nl || rx_data == CH_BS || rx_data == CH_DEL ||
                 rx_data == CH_CTRL_R || rx_data == CH_CTRL_U;
  wire rx_flow = rx_data == CH_XON || rx_data == CH_XOFF;
  // Power-up events carry their text when its length is nonzero; others only in long mode
  logic pup_evt;
  assign pup_evt = code_q == EV_POWER_OK || code_q == EV_SELFTEST;
  wire desc_on = (long_q || pup_evt) && dlen_q != '0; // R14 R17

  // Main sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= S_PUP;
      len_q <= '0;
      idx_q <= '0;
      esc_q <= 1'b0;
      ovf_q <= 1'b0;
      ch_q <= 8'h00;
      caret_q <= 8'h00;
      kind_q <= K_OK;
      last_q <= 1'b0;
      code_q <= '0;
      qlen_q <= '0;
      dlen_q <= '0;
      dig_q <= '0;
      first_q <= 1'b1;
      resp_pend_q <= 1'b0;
      pup_pend_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == A_RESP) begin
        kind_q <= pwdata[R_KIND_LO+1:R_KIND_LO];
        last_q <= pwdata[R_LAST];
        code_q <= pwdata[9:0]; // R15
        qlen_q <= pwdata[23:16];
      end
      if (apb_wr && paddr == A_EVENT)
        dlen_q <= pwdata[23:16];
      case (st_q)
        S_PUP: begin
          if (pup_pend_q) begin
            pup_pend_q <= 1'b0;
            if (verb_q) begin // R17
              code_q <= pfail_q ? EV_SELFTEST : EV_POWER_OK;
              kind_q <= K_EVENT;
              last_q <= 1'b1;
              first_q <= 1'b1;
              st_q <= S_EVT;
              ch_q <= 8'h45;
              idx_q <= '0;
            end else begin
              st_q <= echo_q ? S_PROMPT : S_IDLE; // R18
            end
          end
        end
        S_PROMPT: if (tx_go) st_q <= S_IDLE; // R01
        S_IDLE: begin
          if (!echo_q && resp_pend_q) begin
            resp_pend_q <= 1'b0;
            st_q <= S_RSEP;
          end else if (rx_go && echo_q) begin
            ch_q <= rx_data;
            caret_q <= (rx_data == CH_DEL) ? CH_QMARK
                       : rx_data + CH_CTL_OFS; // R03
            if (esc_q) begin
              esc_q <= 1'b0; // R10
              if (len_q == PTR_W'(LINE_DEPTH)) ovf_q <= 1'b1;
              else len_q <= len_q + 1'b1;
              st_q <= is_ctl(rx_data) ? S_CARET : S_ECHO; // R04
            end else if (rx_data == CH_BSLASH) begin
              esc_q <= 1'b1; // R10
              st_q <= S_ECHO; // R20
            end else if (rx_nl) begin
              st_q <= S_HOLD; // R02
            end else if (rx_data == CH_CTRL_U) begin
              len_q <= '0; // R08
              ovf_q <= 1'b0;
              st_q <= S_PROMPT; // R08
            end else if (rx_data == CH_CTRL_R) begin
              idx_q <= '0; // R07
              st_q <= (len_q == '0) ? S_IDLE : S_RETYPE;
            end else if (rx_data == CH_BS || rx_data == CH_DEL) begin
              if (len_q != '0) begin
                len_q <= len_q - 1'b1; // R09
                st_q <= S_ERASE1;
              end
            end else begin
              if (len_q == PTR_W'(LINE_DEPTH)) ovf_q <= 1'b1; // R06
              else len_q <= len_q + 1'b1;
              if (rx_flow) st_q <= soft_q ? S_IDLE : S_CARET; // R05
              else st_q <= is_ctl(rx_data) ? S_CARET : S_ECHO; // R03
            end
          end
        end
        S_ECHO:  if (tx_go) st_q <= S_IDLE; // R20
        S_CARET: if (tx_go) begin
          ch_q <= caret_q; // R03
          st_q <= S_ECHO;
        end
        S_ERASE1: if (tx_go) st_q <= S_ERASE2; // R09
        S_ERASE2: if (tx_go) st_q <= S_ERASE3;
        S_ERASE3: if (tx_go) st_q <= S_IDLE;
        S_RETYPE: if (tx_go) begin
          idx_q <= idx_q + 1'b1; // R07
          if (idx_q + 1'b1 == len_q) st_q <= S_IDLE;
        end
        S_HOLD: begin
          // Overflowed line never reaches the parser
          if (ovf_q) begin
            ovf_q <= 1'b0; // R06
            len_q <= '0;
            st_q <= S_PROMPT;
          end else if (resp_pend_q) begin
            resp_pend_q <= 1'b0;
            len_q <= '0; // R22
            st_q <= S_RSEP;
          end else if (apb_wr && paddr == A_CTRL && pwdata[B_DONE]) begin
            len_q <= '0; // R22
            first_q <= 1'b1;
            st_q <= S_PROMPT; // R22
          end
        end
        S_RSEP: begin
          idx_q <= '0;
          dig_q <= '0;
          if (!first_q) begin
            if (tx_go) st_q <= kind_q == K_EVENT ? S_EVT : S_RBODY; // R13
          end else
            st_q <= kind_q == K_EVENT ? S_EVT : S_RBODY;
        end
        S_RBODY: if (tx_go) begin
          idx_q <= idx_q + 1'b1; // R11 R12
          if (kind_q == K_OK ? idx_q == 9'd1
                             : idx_q + 1'b1 == {1'b0, qlen_q})
            st_q <= S_EOM;
        end
        S_EVT: if (tx_go) begin
          idx_q <= idx_q + 1'b1; // R14
          if (idx_q == 9'd5) st_q <= S_DIG;
        end
        S_DIG: if (tx_go) begin
          dig_q <= dig_q + 1'b1; // R14
          if (dig_q == 2'd2)
            st_q <= desc_on ? S_COMMA : S_EOM; // R14 R17
        end
        S_COMMA:  if (tx_go) st_q <= S_QUOTE1;
        S_QUOTE1: if (tx_go) begin
          idx_q <= '0;
          st_q <= S_DESC;
        end
        S_DESC: if (tx_go) begin
          idx_q <= idx_q + 1'b1;
          if (idx_q + 1'b1 == {1'b0, dlen_q}) st_q <= S_QUOTE2;
        end
        S_QUOTE2: if (tx_go) st_q <= S_EOM;
        S_EOM: begin
          first_q <= last_q;
          if (last_q) st_q <= echo_q ? S_PROMPT : S_IDLE; // R13 R22
          else st_q <= echo_q ? S_HOLD : S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
      // Set wins over a same-cycle clear, so no request is lost
      if (apb_wr && paddr == A_RESP)
        resp_pend_q <= verb_q || pwdata[R_KIND_LO+1:R_KIND_LO] == K_QUERY;
      if (apb_wr && paddr == A_CTRL && pwdata[B_PUDONE])
        pup_pend_q <= 1'b1;
    end
  end

  // Transmit character selection
  always_comb begin
    tx_valid = 1'b1;
    tx_data  = 8'h00;
    case (st_q)
      S_PROMPT: tx_data = CH_PROMPT;
      S_ECHO:   tx_data = ch_q;
      S_CARET:  tx_data = CH_CARET;
      S_ERASE1, S_ERASE3: tx_data = CH_BS;
      S_ERASE2: tx_data = CH_SPACE;
      S_RETYPE: tx_data = line_mem[idx_q[7:0]];
      S_RSEP:   begin
        tx_valid = !first_q;
        tx_data  = CH_SEMI;
      end
      S_RBODY:  tx_data = kind_q == K_OK ? (idx_q == 0 ? CH_O : CH_K)
                                         : resp_mem[idx_q[7:0] + 8'd1];
      S_EVT: tx_data = idx_q == 0 ? 8'h45 : idx_q == 1 ? 8'h56 :
                       idx_q == 2 ? 8'h45 : idx_q == 3 ? 8'h4e :
                       idx_q == 4 ? 8'h54 : CH_SPACE;
      S_DIG:    tx_data = dec_digit(code_q, dig_q);
      S_COMMA:  tx_data = CH_COMMA;
      S_QUOTE1, S_QUOTE2: tx_data = CH_QUOTE;
      S_DESC:   tx_data = desc_mem[idx_q[5:0]];
      default:  tx_valid = 1'b0;
    endcase
  end
  // End marker rides on the final char of the last response
  always_comb begin
    tx_eom = 1'b0;
    case (st_q)
      S_RBODY:  tx_eom = kind_q == K_OK ? idx_q == 9'd1
                                        : idx_q + 1'b1 == {1'b0, qlen_q};
      S_DIG:    tx_eom = dig_q == 2'd2 && !desc_on;
      S_QUOTE2: tx_eom = 1'b1;
      default:  tx_eom = 1'b0;
    endcase
    tx_eom = tx_eom && last_q; // R13
  end
  assign line_valid = st_q == S_HOLD && !ovf_q;
  assign line_len   = len_q;

  // Queued events: overflow, binary discard, and non-verbose power-up and EVENT responses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_v_q <= 1'b0;
      ev_q <= '0;
    end else begin
      ev_v_q <= 1'b0;
      if (st_q == S_HOLD && ovf_q) begin
        ev_v_q <= 1'b1;
        ev_q <= EV_OVERFLOW; // R06
      end else if (apb_wr && paddr == A_CTRL && pwdata[B_BINARY]
                   && echo_q) begin
        ev_v_q <= 1'b1;
        ev_q <= EV_BINARY; // R21
      end else if (st_q == S_PUP && pup_pend_q && !verb_q) begin
        ev_v_q <= 1'b1;
        ev_q <= pfail_q ? EV_SELFTEST : EV_POWER_OK; // R18
      end else if (apb_wr && paddr == A_RESP && !verb_q &&
                   pwdata[R_KIND_LO+1:R_KIND_LO] == K_EVENT) begin
        ev_v_q <= 1'b1;
        ev_q <= pwdata[9:0]; // R16
      end
    end
  end
  assign event_valid = ev_v_q;
  assign event_code  = ev_q;

  always_comb begin
    prdata = 32'h0;
    if (apb_acc && !pwrite) begin
      case (paddr)
        A_CTRL: begin
          prdata[B_ECHO] = echo_q;
          prdata[B_VERBOSE] = verb_q;
          prdata[B_LONG] = long_q;
          prdata[B_SOFTFLW] = soft_q;
          prdata[B_PFAIL] = pfail_q;
        end
        A_STATUS: prdata = {16'h0, 2'b0, line_valid, ovf_q, esc_q,
                            st_q == S_IDLE, 1'b0, len_q};
        A_LINE: prdata = {24'h0, line_mem[pwdata[7:0]]};
        default: prdata = 32'h0;
      endcase
    end
  end
endmodule

/* File: sel_line_editor_props.sv */
// Port-level concurrent checks for the serial echo line editor
`timescale 1ns/1ns
module sel_line_editor_props
  import sel_pkg::*;
(
  input wire logic        pclk,        // Clock
  input wire logic        presetn,     // Reset, low active
  input wire logic        psel,        // APB select
  input wire logic        penable,     // APB enable
  input wire logic        pwrite,      // APB direction
  input wire logic [7:0]  paddr,       // APB address
  input wire logic [31:0] pwdata,      // APB write data
  input wire logic        pready,      // APB ready
  input wire logic        pslverr,     // APB error
  input wire logic        rx_valid,    // Char offered
  input wire logic [7:0]  rx_data,     // Char offered
  input wire logic        rx_ready,    // Char taken
  input wire logic        tx_valid,    // Char sent
  input wire logic [7:0]  tx_data,     // Char sent
  input wire logic        tx_ready,    // Terminal takes
  input wire logic        tx_eom,      // End marker
  input wire logic        line_valid,  // Line waiting
  input wire logic [8:0]  line_len,    // Line length
  input wire logic        event_valid  // Event pulse
);
  logic       echo_q; // Echo bit as last written
  logic [7:0] rx_q;   // Last taken char
  wire wr_ctrl = psel && penable && pready && pwrite && paddr == A_CTRL;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) echo_q <= 1'b0;
    else if (wr_ctrl) echo_q <= pwdata[B_ECHO];
  end
  always_ff @(posedge pclk) begin
    if (rx_valid && rx_ready) rx_q <= rx_data;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take; echo_q && rx_valid && rx_ready; endsequence
  // Only a waiting line is handed back by the done strobe
  sequence s_done;
    wr_ctrl && pwdata[B_DONE] && pwdata[B_ECHO] && line_valid;
  endsequence
  sequence s_prompt; tx_valid && tx_ready && tx_data == CH_PROMPT; endsequence
  a_ready_high: assert property (pready)
    else $error("pready low");
  a_slverr_map: assert property (psel && penable |->
    pslverr == (paddr > A_DESC)) else $error("pslverr wrong");
  a_tx_hold: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data)) else $error("tx char dropped");
  a_eom_valid: assert property (tx_eom |-> tx_valid)
    else $error("end marker without char");
  a_event_pulse: assert property (event_valid |=> !event_valid)
    else $error("event not a pulse");
  a_line_hold: assert property (
    line_valid && !(wr_ctrl && pwdata[B_DONE]) |=>
    line_valid && $stable(line_len)) else $error("line lost");
  a_line_clear: assert property (s_done |=> ##[0:1] !line_valid)
    else $error("line kept after done");
  a_prompt_done: assert property (s_done |-> ##[1:60] s_prompt)
    else $error("no prompt after done");
  a_len_max: assert property (line_valid |-> line_len <= 9'd256)
    else $error("line too long");
  a_rx_echo: assert property (
    s_take ##0 (rx_data inside {[8'h21:8'h5b], [8'h5d:8'h7e]}) |->
    ##[1:40] tx_valid && tx_data == rx_q) else $error("char not echoed");
  a_caret_ctl: assert property (
    s_take ##0 (rx_data inside {[8'h01:8'h07]}) |->
    ##[1:40] tx_valid && tx_data == CH_CARET) else $error("no caret");
endmodule
bind sel_line_editor sel_line_editor_props sel_line_editor_props_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data),
  .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .tx_eom(tx_eom), .line_valid(line_valid),
  .line_len(line_len), .event_valid(event_valid));

/* File: sel_term.sv */
// Terminal model on the serial side of the line editor
`timescale 1ns/1ns
module sel_term (
  input  wire logic       pclk,     // Clock
  input  wire logic       presetn,  // Reset, low active
  output logic            rx_valid, // Char to editor
  output logic [7:0]      rx_data,  // Char value
  input  wire logic       rx_ready, // Editor takes char
  input  wire logic       tx_valid, // Char from editor
  input  wire logic [7:0] tx_data,  // Char value
  output logic            tx_ready  // Terminal takes char
);
  logic [1:0] cnt_q;  // Stall pattern
  logic [7:0] got[$]; // Characters shown on screen
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
  end
  // Stalls one cycle in four so held chars are exercised
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= 2'h0;
      tx_ready <= 1'b0;
    end else begin
      cnt_q    <= cnt_q + 2'h1;
      tx_ready <= cnt_q != 2'h3;
      if (tx_valid && tx_ready) got.push_back(tx_data);
    end
  end
  task automatic send(input logic [7:0] c);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data  <= c;
    @(posedge pclk);
    while (rx_ready !== 1'b1) @(posedge pclk);
    rx_valid <= 1'b0;
    rx_data  <= ~c; // Released line shows no stale value
  endtask
endmodule

/* File: tb.sv */
// Self-checking bench for the serial echo line editor
`timescale 1ns/1ns
module tb;
  import sel_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        pv_set, pv_clr, rx_valid, rx_ready, tx_valid, tx_ready;
  logic        tx_eom, line_valid, event_valid, err;
  logic [7:0]  paddr, rx_data, tx_data;
  logic [8:0]  line_len;
  logic [9:0]  event_code;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0]  evq[$];
  int          num_errors = 0;
  int          checks     = 0;
  int          cyc        = 0;
  int          eoms       = 0;
  sel_line_editor sel_line_editor_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .panel_verbose_set(pv_set), .panel_verbose_clr(pv_clr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .tx_eom(tx_eom), .line_valid(line_valid), .line_len(line_len),
    .event_valid(event_valid), .event_code(event_code));
  sel_term sel_term_inst (.pclk(pclk), .presetn(presetn),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (event_valid === 1'b1) evq.push_back(event_code);
    if (tx_valid === 1'b1 && tx_ready === 1'b1 && tx_eom === 1'b1)
      eoms <= eoms + 1;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks=%0d errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic typ(input string s);
    foreach (s[i]) sel_term_inst.send(s[i]);
  endtask
  // Exact match, or only the tail where framing chars may precede it
  task automatic see(input string s, input bit exact);
    int n;
    repeat (80) @(posedge pclk);
    n = sel_term_inst.got.size();
    if (exact) chk(n, s.len());
    else chk(n >= s.len(), 1);
    for (int i = 0; i < s.len() && n >= s.len(); i++)
      chk(sel_term_inst.got[n - s.len() + i], s[i]);
    sel_term_inst.got.delete();
  endtask
  task automatic ev(input logic [9:0] c);
    repeat (2) @(posedge pclk);
    chk(evq.size(), 1);
    if (evq.size() > 0) chk(evq.pop_front(), c);
    evq.delete();
  endtask
  task automatic pan(input bit on);
    @(posedge pclk);
    pv_set <= on;
    pv_clr <= !on;
    @(posedge pclk);
    pv_set <= 1'b0;
    pv_clr <= 1'b0;
  endtask
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, pv_set, pv_clr} = 5'h00;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1, A_CTRL, 32'h21);
    see(">", 0);
    ev(EV_POWER_OK);
    $display("test powerup done");
    typ("A\x01");
    see("A^A", 1);
    typ("\r");
    see("", 0);
    chk(line_valid, 1);
    chk(line_len, 2);
    apb(1, A_CTRL, 32'h61);
    see(">", 0);
    chk(line_valid, 0);
    $display("test line done");
    typ("BC\x08");
    see("BC\x08 \x08", 1);
    typ("D\x7f");
    see("D\x08 \x08", 1);
    typ("\x12");
    see("B", 0);
    typ("\x15");
    see(">", 0);
    typ("\\\\\\\r");
    see("^M", 0);
    typ("\r");
    see("", 0);
    chk(line_len, 2);
    apb(1, A_CTRL, 32'h61);
    see(">", 0);
    $display("test edit done");
    typ("\x11");
    see("^Q", 1);
    apb(1, A_CTRL, 32'h29);
    typ("\x13");
    see("", 1);
    apb(1, A_CTRL, 32'h21);
    typ("\x15");
    see(">", 0);
    apb(1, A_CTRL, 32'h81);
    ev(EV_BINARY);
    $display("test flow done");
    for (int i = 0; i < 257; i++) sel_term_inst.send(8'h78);
    sel_term_inst.send(CH_CR);
    see(">", 0);
    ev(EV_OVERFLOW);
    chk(line_valid, 0);
    $display("test overflow done");
    apb(1, A_CTRL, 32'h20);
    see("", 0);
    pan(1'b1);
    apb(0, A_CTRL, 32'h0);
    chk(rd, 32'h2);
    apb(1, A_RESP, 32'h1000);
    see("OK", 0);
    chk(eoms, 1);
    apb(1, A_RESP, 32'h089d);
    repeat (40) @(posedge pclk);
    apb(1, A_RESP, 32'h1000);
    see("EVENT 157;OK", 1);
    chk(eoms, 2);
    pan(1'b0);
    apb(1, A_RESP, 32'h1000);
    see("", 1);
    apb(1, A_LINE, 32'h0151);
    apb(1, A_RESP, 32'h0001_1400);
    see("Q", 1);
    apb(0, 8'h18, 32'h0);
    chk(err, 1);
    $display("test verbose done");
    // Second power-up, this time with verbose on
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1, A_EVENT, 32'h0002_0000);
    apb(1, A_DESC, 32'h0075);
    apb(1, A_DESC, 32'h0170);
    apb(1, A_CTRL, 32'h22);
    see("EVENT 401,\"up\"", 1);
    chk(eoms, 4);
    chk(evq.size(), 0);
    $display("test reset done");
    stop_test();
  end
endmodule
